// [hdl/tfc_pkg.sv]
// constants shared by the two-phase fan commutator core
// assumes a single 100 MHz clock and levels coded as volts * 64
package tfc_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PER_MS = 1000000 / CLK_PERIOD_NS;

  // speed level coding: one volt is 64 codes
  localparam int LEVEL_W = 8;
  localparam int LEVEL_PER_VOLT = 64;
  localparam logic [7:0] LEVEL_FULL = 8'h40; // 1 V, full drive
  localparam logic [7:0] LEVEL_OFF = 8'hC0; // 3 V, no drive
  localparam logic [7:0] LEVEL_REF = 8'hC0; // nominal reference level

  // carrier: triangle between LEVEL_FULL and LEVEL_OFF
  localparam int PWM_FREQ_HZ = 24000;
  localparam int PWM_PERIOD_CYC = 1000000000 / (PWM_FREQ_HZ * CLK_PERIOD_NS);
  localparam int CARRIER_SPAN = 128;
  localparam int CARRIER_STEP_CYC = PWM_PERIOD_CYC / (2 * CARRIER_SPAN);

  // gap between releasing one phase and driving the other
  localparam int COMM_GAP_NS = 7500;
  localparam int COMM_GAP_CYC =
    (COMM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // rotor lock timing
  localparam int LOCK_TIME_MS = 300;
  localparam int RETRY_ON_MS = 250;
  localparam int RETRY_OFF_RATIO = 12;

  // lock supervisor states, gray along run -> off -> on
  typedef enum logic [1:0] {
    TFC_RUN = 2'b00,
    TFC_LOCK_OFF = 2'b01,
    TFC_LOCK_ON = 2'b11
  } tfc_lock_e;

endpackage

// [hdl/tfc_sync2.sv]
// two-flop synchroniser for pin inputs
// assumes the input is asynchronous to clock
`timescale 1ns/100ps
module tfc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // async in, synced out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // tfc_sync2

// [hdl/tfc_core.sv]
// control core of a two-phase brushless fan pre-driver
// assumes hall comparator output arrives asynchronously on a pin and
// speed / floor levels come from a converter on the same clock
`timescale 1ns/100ps

// Functional notes
// RL1 - hall positive above negative selects phase two
// RL2 - 3V level gives 0%, 1V gives 100%
// RL3 - level above 3V forces drive off
// RL4 - grounded level gives continuous full drive
// RL5 - used level clamped to floor level
// RL6 - floor held at reference when unused
// RL7 - carrier period about 24kHz
// RL8 - stall timeout raises lock, disables phases
// RL9 - locked: off time, on time, repeat
// RL10 - retry on to off ratio 1:12
// RL11 - lock flag released stopped, pulled running
// RL12 - tach output copies hall state
// RL13 - active phase carries the pwm waveform
// RL14 - inactive phase low, active low when off
// RL15 - never both phases, gap before switching
// RL16 - hall edges clear lock state, flag
// RL17 - drive high while carrier above level
module tfc_core #(
  parameter int LOCK_CYCLES = tfc_pkg::LOCK_TIME_MS * tfc_pkg::CLK_PER_MS,
  parameter int RETRY_ON_CYCLES = tfc_pkg::RETRY_ON_MS * tfc_pkg::CLK_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // hall comparator, high when positive input above negative
  input wire logic hall_above,
  // speed and floor levels, volts * 64
  input wire logic [7:0] speed_level_in,
  input wire logic [7:0] floor_level_in,
  // phase drives
  output logic phase_one_drive,
  output logic phase_two_drive,
  // reference level for the floor divider
  output logic [7:0] reference_level_out,
  // tachometer open collector, oe pulls low
  input wire logic tach_out_in,
  output logic tach_out_o,
  output logic tach_out_oe,
  // lock flag open collector, oe pulls low
  input wire logic lock_flag_in,
  output logic lock_flag_o,
  output logic lock_flag_oe
);

  localparam int RETRY_OFF_CYCLES = RETRY_ON_CYCLES * tfc_pkg::RETRY_OFF_RATIO;
  localparam int GAP_W = $clog2(tfc_pkg::COMM_GAP_CYC + 1);
  localparam int STEP_W = $clog2(tfc_pkg::CARRIER_STEP_CYC + 1);
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(tfc_pkg::COMM_GAP_CYC);
  localparam logic [STEP_W-1:0] STEP_LAST =
    STEP_W'(tfc_pkg::CARRIER_STEP_CYC - 1);
  localparam logic [31:0] LOCK_LAST = 32'(LOCK_CYCLES - 1);
  localparam logic [31:0] ON_LAST = 32'(RETRY_ON_CYCLES - 1);
  localparam logic [31:0] OFF_LAST = 32'(RETRY_OFF_CYCLES - 1);

  logic hall_s;
  logic active_two;
  logic next_active_two;
  logic [GAP_W-1:0] gap;
  logic [GAP_W-1:0] next_gap;
  logic hall_edge;
  logic [7:0] carrier;
  logic [7:0] next_carrier;
  logic carrier_up;
  logic next_carrier_up;
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] next_step;
  logic [7:0] eff_level;
  logic pwm_on;
  tfc_pkg::tfc_lock_e lock_state;
  tfc_pkg::tfc_lock_e next_lock_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic drive_ok;
  logic next_phase_one;
  logic next_phase_two;

  // hall comparator comes straight off a pin
  tfc_sync2 #(.WIDTH(1)) u_hall_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(hall_above),
    .sync_out(hall_s)
  );

  // pad inputs are not needed; the pins are drive-only open collector
  assign tach_out_o = 1'b0;
  assign lock_flag_o = 1'b0;

  // commutation: follow hall, blank both phases for the gap
  always_comb begin
    hall_edge = hall_s != active_two;
    next_active_two = hall_s; // see RL1
    if (hall_edge) begin
      next_gap = GAP_LOAD; // see RL15
    end else if (gap != '0) begin
      next_gap = gap - 1'b1;
    end else begin
      next_gap = gap;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_two <= 1'b0;
      gap <= '0;
    end else begin
      active_two <= next_active_two;
      gap <= next_gap;
    end
  end

  // triangle carrier; step rate sets the carrier period
  always_comb begin
    next_step = step;
    next_carrier = carrier;
    next_carrier_up = carrier_up;
    if (step == STEP_LAST) begin
      next_step = '0;
      if (carrier_up) begin
        next_carrier = carrier + 8'h01; // see RL7
        if (carrier == tfc_pkg::LEVEL_OFF - 8'h01) begin
          next_carrier_up = 1'b0;
        end
      end else begin
        next_carrier = carrier - 8'h01;
        if (carrier == tfc_pkg::LEVEL_FULL + 8'h01) begin
          next_carrier_up = 1'b1;
        end
      end
    end else begin
      next_step = step + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step <= '0;
      carrier <= tfc_pkg::LEVEL_FULL;
      carrier_up <= 1'b1;
    end else begin
      step <= next_step;
      carrier <= next_carrier;
      carrier_up <= next_carrier_up;
    end
  end

  // level clamp and compare; carrier never exceeds 3 V so a level at
  // or above it gives no drive, and ground always drives
  always_comb begin
    if (speed_level_in > floor_level_in) begin
      eff_level = floor_level_in; // see RL5
    end else begin
      eff_level = speed_level_in;
    end
    // see RL2, RL4, RL17
    pwm_on = (carrier > eff_level) &&
             (speed_level_in <= tfc_pkg::LEVEL_OFF); // see RL3
  end

  // lock supervisor: one timer serves stall, off and on intervals
  always_comb begin
    next_lock_state = lock_state;
    next_timer = timer + 32'h00000001;
    if (hall_edge) begin
      next_lock_state = tfc_pkg::TFC_RUN; // see RL16
      next_timer = '0;
    end else begin
      unique case (lock_state)
        tfc_pkg::TFC_RUN: begin
          if (timer == LOCK_LAST) begin
            next_lock_state = tfc_pkg::TFC_LOCK_OFF; // see RL8
            next_timer = '0;
          end
        end
        tfc_pkg::TFC_LOCK_OFF: begin
          if (timer == OFF_LAST) begin
            next_lock_state = tfc_pkg::TFC_LOCK_ON; // see RL9, RL10
            next_timer = '0;
          end
        end
        tfc_pkg::TFC_LOCK_ON: begin
          if (timer == ON_LAST) begin
            next_lock_state = tfc_pkg::TFC_LOCK_OFF; // see RL9
            next_timer = '0;
          end
        end
        default: begin
          next_lock_state = tfc_pkg::TFC_RUN;
          next_timer = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_state <= tfc_pkg::TFC_RUN;
      timer <= '0;
    end else begin
      lock_state <= next_lock_state;
      timer <= next_timer;
    end
  end

  // outputs from next values so they line up with the state flops
  always_comb begin
    drive_ok = (next_lock_state != tfc_pkg::TFC_LOCK_OFF) && // see RL8
               (next_gap == '0) && pwm_on;
    next_phase_two = drive_ok && next_active_two; // see RL13, RL14
    next_phase_one = drive_ok && !next_active_two; // see RL14, RL15
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_one_drive <= 1'b0;
      phase_two_drive <= 1'b0;
      tach_out_oe <= 1'b1;
      lock_flag_oe <= 1'b1;
      reference_level_out <= tfc_pkg::LEVEL_REF;
    end else begin
      phase_one_drive <= next_phase_one;
      phase_two_drive <= next_phase_two;
      tach_out_oe <= !next_active_two; // see RL12
      // released while locked, pulled low while running
      lock_flag_oe <= next_lock_state == tfc_pkg::TFC_RUN; // see RL11
      reference_level_out <= tfc_pkg::LEVEL_REF;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_phase_exclusive: assert property ( // see RL15
    !(phase_one_drive && phase_two_drive))
    else $error("both phases driven");

  a_gap_blank: assert property ( // see RL15
    $changed(active_two) |->
      (!phase_one_drive && !phase_two_drive) [*8])
    else $error("phase driven inside commutation gap");

  a_inactive_low: assert property ( // see RL14
    (active_two |-> !phase_one_drive) and
    (!active_two |-> !phase_two_drive))
    else $error("inactive phase driven");

  a_lock_entry: assert property ( // see RL8
    (lock_state == tfc_pkg::TFC_RUN && timer == LOCK_LAST && !hall_edge)
      |=> (lock_state == tfc_pkg::TFC_LOCK_OFF && !phase_one_drive &&
           !phase_two_drive && !lock_flag_oe))
    else $error("stall not turned into lock");

  a_lock_off_quiet: assert property ( // see RL8
    lock_state == tfc_pkg::TFC_LOCK_OFF |->
      (!phase_one_drive && !phase_two_drive))
    else $error("drive while locked off");

  a_retry_ratio: assert property ( // see RL10
    $rose(lock_state == tfc_pkg::TFC_LOCK_ON) |->
      $past(timer) == OFF_LAST)
    else $error("retry off interval wrong");

  a_retry_end: assert property ( // see RL9
    (lock_state == tfc_pkg::TFC_LOCK_ON && timer == ON_LAST && !hall_edge)
      |=> lock_state == tfc_pkg::TFC_LOCK_OFF)
    else $error("retry on interval wrong");

  a_resume_run: assert property ( // see RL16
    hall_edge |=> (lock_state == tfc_pkg::TFC_RUN && lock_flag_oe))
    else $error("hall edge did not clear lock");

  a_tach_copy: assert property ( // see RL12
    tach_out_oe != active_two)
    else $error("tach not following hall");

  a_full_drive: assert property ( // see RL4
    (speed_level_in == 8'h00 && next_gap == '0 &&
     next_lock_state == tfc_pkg::TFC_RUN)
      |=> (phase_one_drive || phase_two_drive))
    else $error("grounded level not full drive");

  a_over_off: assert property ( // see RL3
    speed_level_in > tfc_pkg::LEVEL_OFF |=>
      (!phase_one_drive && !phase_two_drive))
    else $error("drive above off level");

  c_lock_retry: cover property (
    $rose(lock_state == tfc_pkg::TFC_LOCK_ON));
  c_commutate: cover property (
    $changed(active_two) ##[1:1000] phase_two_drive);
  c_pwm_toggle: cover property (
    phase_one_drive ##1 !phase_one_drive ##[1:300] phase_one_drive);

endmodule // tfc_core

// [verification/tfc_motor_model.sv]
// rotor and power stage seen from the two phase drives
// assumes drives are sampled on the rising clock edge
`timescale 1ns/100ps
module tfc_motor_model #(
  parameter int TURN_CYC = 50
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // phase drives from the core
  input wire logic phase_one_drive,
  input wire logic phase_two_drive,
  // bench control: stall holds the rotor at hold_level
  input wire logic stall,
  input wire logic hold_level,
  // hall comparator level
  output logic hall_above
);
  int cnt;

  // rotor advances one pole after TURN_CYC cycles of the right drive;
  // a stalled rotor is pinned, so drive has no effect
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hall_above <= 1'b0;
      cnt <= 0;
    end else if (stall) begin
      hall_above <= hold_level;
      cnt <= 0;
    end else if (hall_above ? phase_two_drive : phase_one_drive) begin
      cnt <= (cnt == TURN_CYC - 1) ? 0 : cnt + 1;
      if (cnt == TURN_CYC - 1) hall_above <= !hall_above;
    end
  end
endmodule // tfc_motor_model

// [verification/two_phase_fan_commutator_tb.sv]
// self-checking bench for the fan commutator core
// assumes a rotor model as partner and shortened lock timing
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: mismatch", $time); end end
module two_phase_fan_commutator_tb;
  localparam int LOCK = 20000;
  localparam int RON = 100;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hall_above, stall = 1'b1, hold_level = 1'b0;
  logic [7:0] speed_level_in = 8'h00, floor_level_in = 8'hC0;
  logic phase_one_drive, phase_two_drive, tach_out_o, tach_out_oe;
  logic lock_flag_o, lock_flag_oe;
  logic [7:0] reference_level_out;
  logic [15:0] lfsr = 16'h9684;
  wire tach_pin = tach_out_oe ? 1'b0 : 1'b1; // pull-up on the pad
  wire lock_pin = lock_flag_oe ? 1'b0 : 1'b1;
  int errors = 0, total_checks = 0, n;
  integer c1, c2; // four-state so an unknown drive spoils the count

  always #5 clock = ~clock;

  tfc_core #(.LOCK_CYCLES(LOCK), .RETRY_ON_CYCLES(RON)) u_tfc_core (
    .clock(clock), .reset_n(reset_n), .hall_above(hall_above),
    .speed_level_in(speed_level_in), .floor_level_in(floor_level_in),
    .phase_one_drive(phase_one_drive), .phase_two_drive(phase_two_drive),
    .reference_level_out(reference_level_out), .tach_out_in(tach_pin),
    .tach_out_o(tach_out_o), .tach_out_oe(tach_out_oe),
    .lock_flag_in(lock_pin), .lock_flag_o(lock_flag_o),
    .lock_flag_oe(lock_flag_oe));

  tfc_motor_model #(.TURN_CYC(50)) u_tfc_motor_model (
    .clock(clock), .reset_n(reset_n), .phase_one_drive(phase_one_drive),
    .phase_two_drive(phase_two_drive), .stall(stall),
    .hold_level(hold_level), .hall_above(hall_above));

  // galois lfsr, taps 16,14,13,11
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
  endfunction

  // on-cycles per 4096-cycle carrier period for a speed/floor pair
  function automatic int exp_on(logic [7:0] s, logic [7:0] f);
    int lvl;
    lvl = (s < f) ? s : f;
    if (s > 8'hC0) return 0;
    if (lvl <= 8'h40) return 4096;
    return (8'hC0 - lvl) * 32;
  endfunction

  function automatic logic near(integer v, int e, int tol);
    return (v >= e - tol) && (v <= e + tol);
  endfunction

  task automatic meas(input int len);
    c1 = 0;
    c2 = 0;
    repeat (len) begin
      @(negedge clock);
      c1 += phase_one_drive;
      c2 += phase_two_drive;
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the tests need about 59k cycles
  initial begin
    #1000000;
    errors++;
    final_report();
  end

  initial begin
    repeat (2) @(negedge clock);
    `CHK({phase_one_drive, phase_two_drive, tach_out_oe, lock_flag_oe},
      4'h3)
    `CHK(reference_level_out, 8'hC0)
    @(negedge clock);
    reset_n = 1'b1;
    $display("test reset done");
    // commutation, gap and tach copy for each hall level
    for (int i = 0; i < 3; i++) begin
      hold_level = (i != 1);
      repeat (4) @(negedge clock);
      `CHK(tach_out_oe, !hold_level)
      `CHK(tach_out_o, 1'b0)
      repeat (740) @(negedge clock);
      `CHK({phase_one_drive, phase_two_drive}, 2'b00)
      repeat (20) @(negedge clock);
      `CHK(phase_two_drive, hold_level)
      `CHK(phase_one_drive, !hold_level)
    end
    $display("test commutation done");
    // duty: grounded, disabled, top of range, one random speed, then random pairs
    for (int i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      speed_level_in = (i == 0) ? 8'h00 : (i == 1) ? 8'hD0 :
        (i == 2) ? 8'hC0 : 8'(lfsr[7:0] % 8'h81 + 8'h40);
      lfsr = lfsr_next(lfsr);
      floor_level_in = (i < 4) ? reference_level_out :
        8'(lfsr[7:0] % 8'hC0 + 8'h40);
      hold_level = !hold_level;
      repeat (800) @(negedge clock);
      meas(4096);
      `CHK(hold_level ? c1 : c2, 0)
      `CHK(near(hold_level ? c2 : c1, exp_on(speed_level_in,
        floor_level_in), 40), 1'b1)
    end
    $display("test duty done");
    // stall: lock timeout, off time, on burst, then restart
    speed_level_in = 8'h00;
    floor_level_in = 8'hC0;
    hold_level = !hold_level;
    n = 0;
    while (lock_flag_oe !== 1'b0 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    `CHK(near(n, LOCK + 3, 4), 1'b1)
    `CHK(lock_pin, 1'b1)
    n = 0;
    while (phase_one_drive !== 1'b1 && phase_two_drive !== 1'b1
      && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHK(near(n, 12 * RON, 3), 1'b1)
    meas(300);
    `CHK(near(c1 + c2, RON - 1, 3), 1'b1)
    `CHK(lock_flag_oe, 1'b0)
    `CHK(lock_flag_o, 1'b0)
    stall = 1'b0;
    n = 0;
    while (lock_flag_oe !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHK(lock_pin, 1'b0)
    `CHK(reference_level_out, 8'hC0)
    $display("test lock done");
    final_report();
  end
endmodule // two_phase_fan_commutator_tb
